// file: dcpm_ctrl.sv
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module dcpm_ctrl
   import dcpm_pkg::*;
#(
   parameter int RTC_W       = RTC_BITS,
   parameter int FAST_SETTLE = FAST_STABLE_CYC,
   parameter int XTAL_SETTLE = XTAL_STABLE_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   input  wire dcpm_pkg::dcpm_wake_t wake,
   input  wire logic                 xtal_in,
   output logic                      xtal_out,
   output logic                      xtal_out_en,
   output dcpm_pkg::dcpm_clk_t       clks,
   output logic                      divided_fast_clock,
   output logic                      slow_clock,
   output logic                      cpu_clock,
   output dcpm_pkg::dcpm_mode_t      mode
);
   import dcpm_pkg::*;

   // Counters below are sized for these limits
   if (RTC_W != RTC_BITS) begin
      $error("RTC width must match the tap bus");
   end
   if (FAST_SETTLE < 1 || FAST_SETTLE > 4095 || XTAL_SETTLE < 1 || XTAL_SETTLE > 4095) begin
      $error("Settle counts must lie in 1 to 4095");
   end
   if (SLOW_DIV_CYC > 1024) begin
      $error("Slow divider exceeds its counter");
   end

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   logic        wr_pend_q;
   logic [31:0] waddr_q;
   logic        rd_sel;
   logic [7:0]  mode_ctrl_q;
   logic [2:0]  hrc_sel_q;
   logic        xtal_sel_q;
   logic        rtc_clr;
   logic        sleep_req;
   logic        wr_mode;
   logic        wr_opt;

   assign rd_sel    = hsel && hready && htrans[1] && !hwrite;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign wr_mode   = wr_pend_q && waddr_q == ADDR_MODE_CTRL;
   assign wr_opt    = wr_pend_q && waddr_q == ADDR_OPTION;
   assign rtc_clr   = wr_mode && !hwdata[BIT_RTC_CLR];
   assign sleep_req = wr_pend_q && waddr_q == ADDR_SLEEP_CMD
                      && hwdata[7:0] == SLEEP_KEY;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_q <= 1'b0;
         waddr_q   <= 32'h0000_0000;
      end else begin
         wr_pend_q <= hsel && hready && htrans[1] && hwrite;
         waddr_q   <= haddr;
      end
   end

   // Bit 2 is a strobe only; it always reads back high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_ctrl_q <= MODE_RESET;
      end else if (wr_mode) begin
         mode_ctrl_q <= {hwdata[7:3], 1'b1, 2'b00};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hrc_sel_q  <= HRC_RESET;
         xtal_sel_q <= 1'b0;
      end else if (wr_opt) begin
         hrc_sel_q  <= hwdata[2:0] > HRC_RESET ? HRC_RESET : hwdata[2:0];
         xtal_sel_q <= hwdata[4];
      end
   end

   logic stable_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_sel) begin
         unique case (haddr)
            ADDR_MODE_CTRL: hrdata <= {24'h00_0000, mode_ctrl_q};
            ADDR_STATUS:    hrdata <= {29'h0000_0000, stable_q, mode};
            ADDR_OPTION:    hrdata <= {27'h000_0000, xtal_sel_q, 2'b00, hrc_sel_q[1:0]};
            default:        hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // Mode sequencer
   // ----------------------------------------
   logic wake_any;
   logic wake_halt;
   logic [11:0] stab_cnt_q;
   logic [11:0] stab_need;
   dcpm_mode_t  mode_q;

   assign wake_any  = |wake;
   assign wake_halt = wake.key_change | wake.ext_irq;
   assign stab_need = mode_ctrl_q[BIT_CPU_SEL] ? 12'(FAST_SETTLE)
                      : (xtal_sel_q ? 12'(XTAL_SETTLE) : 12'(IRC_STABLE_CYC));
   assign mode      = mode_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= MODE_NORMAL;
      end else begin
         unique case (mode_q)
            MODE_NORMAL, MODE_SLOW: begin
               if (sleep_req)
                  mode_q <= mode_ctrl_q[BIT_RTC_EN] ? MODE_STANDBY : MODE_HALT;
               else
                  mode_q <= mode_ctrl_q[BIT_CPU_SEL] ? MODE_NORMAL : MODE_SLOW;
            end
            MODE_STANDBY: if (wake_any)
               mode_q <= mode_ctrl_q[BIT_CPU_SEL] ? MODE_NORMAL : MODE_SLOW;
            MODE_HALT: if (wake_halt)
               mode_q <= mode_ctrl_q[BIT_CPU_SEL] ? MODE_NORMAL : MODE_SLOW;
         endcase
      end
   end

   // CPU clock held off after any source change until the new source settles
   logic [1:0] prev_src_q;
   logic       src_chg;
   // Combinational so the very cycle that enters a new mode is already gated
   assign src_chg = prev_src_q != {mode_q == MODE_NORMAL, mode_q == MODE_SLOW};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_src_q <= 2'b10;
         stab_cnt_q <= 12'h000;
         stable_q   <= 1'b1;
      end else begin
         prev_src_q <= {mode_q == MODE_NORMAL, mode_q == MODE_SLOW};
         if (src_chg) begin
            stab_cnt_q <= 12'h000;
            stable_q   <= 1'b0;
         end else if (!stable_q) begin
            stab_cnt_q <= stab_cnt_q + 12'h001;
            stable_q   <= stab_cnt_q + 12'h001 >= stab_need;
         end
      end
   end

   // ----------------------------------------
   // Clock enables
   // ----------------------------------------
   logic [7:0]  fast_cnt_q;
   logic [7:0]  fast_mask;
   logic [9:0]  slow_cnt_q;
   logic        fast_tick;
   logic        slow_tick;
   logic        fast_on;
   logic        slow_on;
   logic [RTC_W-1:0] rtc_q;

   assign fast_on   = mode_q == MODE_NORMAL;
   assign slow_on   = mode_q != MODE_HALT
                      && (mode_q != MODE_NORMAL || mode_ctrl_q[BIT_RTC_EN]);
   assign fast_mask = 8'((1 << mode_ctrl_q[DIV_HI:DIV_LO]) - 1);
   assign fast_tick = fast_on && (fast_cnt_q & fast_mask) == 8'h00;
   assign slow_tick = slow_on && slow_cnt_q == 10'(SLOW_DIV_CYC - 1);

   // Fast source runs at the top rate; lower RC choices divide further
   logic [2:0] pre_cnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt_q  <= 3'h0;
         fast_cnt_q <= 8'h00;
      end else if (fast_on) begin
         pre_cnt_q <= pre_cnt_q + 3'h1;
         if (pre_cnt_q >= 3'(3 - hrc_sel_q)) begin
            pre_cnt_q  <= 3'h0;
            fast_cnt_q <= fast_cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slow_cnt_q <= 10'h000;
      end else if (slow_on) begin
         slow_cnt_q <= slow_tick ? 10'h000 : slow_cnt_q + 10'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rtc_q <= '0;
      end else if (rtc_clr) begin
         rtc_q <= '0;
      end else if (slow_tick && mode_ctrl_q[BIT_RTC_EN]) begin
         rtc_q <= rtc_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         divided_fast_clock <= 1'b0;
         slow_clock         <= 1'b0;
         cpu_clock          <= 1'b0;
      end else begin
         divided_fast_clock <= fast_tick && pre_cnt_q == 3'h0;
         slow_clock         <= slow_tick;
         cpu_clock          <= stable_q && !src_chg && ((mode_q == MODE_NORMAL && fast_tick && pre_cnt_q == 3'h0)
                               || (mode_q == MODE_SLOW && slow_tick));
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xtal_out    <= 1'b0;
         xtal_out_en <= 1'b0;
      end else begin
         xtal_out    <= !xtal_in;
         xtal_out_en <= xtal_sel_q && slow_on;
      end
   end

   always_comb begin
      clks.cpu_clk_en      = stable_q && !src_chg && (mode_q == MODE_NORMAL || mode_q == MODE_SLOW);
      clks.fast_osc_on     = fast_on;
      clks.slow_osc_on     = slow_on;
      clks.divided_fast_en = fast_on;
      clks.slow_en         = slow_on;
      clks.rtc_taps        = mode_ctrl_q[BIT_RTC_EN] && slow_on ? rtc_q : '0;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_sleep_standby;
      @(posedge clk) disable iff (!rst_n)
      sleep_req && mode_ctrl_q[BIT_RTC_EN] && mode_q == MODE_NORMAL |=> mode_q == MODE_STANDBY;
   endproperty
   a_sleep_standby: assert property (p_sleep_standby) else $error("Sleep did not reach standby");
   property p_halt_clocks;
      @(posedge clk) disable iff (!rst_n)
      mode_q == MODE_HALT |-> !slow_on && !fast_on;
   endproperty
   a_halt_clocks: assert property (p_halt_clocks) else $error("Clock running in halt");
   property p_halt_wake;
      @(posedge clk) disable iff (!rst_n)
      mode_q == MODE_HALT && !wake_halt |=> mode_q == MODE_HALT;
   endproperty
   a_halt_wake: assert property (p_halt_wake) else $error("Halt left without wake");
   property p_resume;
      @(posedge clk) disable iff (!rst_n)
      mode_q == MODE_STANDBY && wake_any && mode_ctrl_q[BIT_CPU_SEL] |=> mode_q == MODE_NORMAL;
   endproperty
   a_resume: assert property (p_resume) else $error("Wrong resume mode");
   property p_rtc_clear;
      @(posedge clk) disable iff (!rst_n)
      rtc_clr |=> rtc_q == '0;
   endproperty
   a_rtc_clear: assert property (p_rtc_clear) else $error("RTC not cleared");
   property p_cpu_hold;
      @(posedge clk) disable iff (!rst_n)
      !stable_q |=> !cpu_clock;
   endproperty
   a_cpu_hold: assert property (p_cpu_hold) else $error("CPU clock before stable");
   property p_slow_no_fast;
      @(posedge clk) disable iff (!rst_n)
      mode_q == MODE_SLOW |-> !fast_on && slow_on;
   endproperty
   a_slow_no_fast: assert property (p_slow_no_fast) else $error("Slow mode clocks wrong");
   property p_bit2_read;
      @(posedge clk) disable iff (!rst_n)
      rd_sel && haddr == ADDR_MODE_CTRL |=> hrdata[BIT_RTC_CLR];
   endproperty
   a_bit2_read: assert property (p_bit2_read) else $error("Bit 2 reads low");
   property p_cpu_gate;
      @(posedge clk) disable iff (!rst_n)
      $changed(mode_q) |-> !clks.cpu_clk_en ##1 !cpu_clock;
   endproperty
   a_cpu_gate: assert property (p_cpu_gate) else $error("CPU clock on unsettled source");
   property p_standby_hold;
      @(posedge clk) disable iff (!rst_n)
      mode_q == MODE_STANDBY && !wake_any |=> mode_q == MODE_STANDBY;
   endproperty
   a_standby_hold: assert property (p_standby_hold) else $error("Standby left without wake");
   property p_standby_clocks;
      @(posedge clk) disable iff (!rst_n)
      mode_q == MODE_STANDBY |-> !fast_on && slow_on && !clks.cpu_clk_en;
   endproperty
   a_standby_clocks: assert property (p_standby_clocks) else $error("Standby clocks wrong");
   property p_sleep_ignore;
      @(posedge clk) disable iff (!rst_n)
      wr_pend_q && waddr_q == ADDR_SLEEP_CMD && hwdata[7:0] != SLEEP_KEY
      && mode_q == MODE_NORMAL && mode_ctrl_q[BIT_CPU_SEL] |=> mode_q == MODE_NORMAL;
   endproperty
   a_sleep_ignore: assert property (p_sleep_ignore) else $error("Wrong sleep value accepted");
   property p_rtc_hold;
      @(posedge clk) disable iff (!rst_n)
      !mode_ctrl_q[BIT_RTC_EN] && !rtc_clr |=> $stable(rtc_q);
   endproperty
   a_rtc_hold: assert property (p_rtc_hold) else $error("RTC counts while disabled");
   property p_halt_slow;
      @(posedge clk) disable iff (!rst_n)
      mode_q == MODE_HALT && wake_halt && !mode_ctrl_q[BIT_CPU_SEL] |=> mode_q == MODE_SLOW;
   endproperty
   a_halt_slow: assert property (p_halt_slow) else $error("Halt did not resume slow");
endmodule
`default_nettype wire

// file: dcpm_pkg.sv
`default_nettype none
package dcpm_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [31:0] ADDR_MODE_CTRL  = 32'h0000_0000;
   localparam logic [31:0] ADDR_SLEEP_CMD  = 32'h0000_0004;
   localparam logic [31:0] ADDR_STATUS     = 32'h0000_0008;
   localparam logic [31:0] ADDR_OPTION     = 32'h0000_000c;
   localparam logic [7:0]  SLEEP_KEY       = 8'h5a;
   localparam int          BIT_CPU_SEL     = 7;
   localparam int          DIV_HI          = 6;
   localparam int          DIV_LO          = 4;
   localparam int          BIT_RTC_EN      = 3;
   localparam int          BIT_RTC_CLR     = 2;
   localparam logic [7:0]  MODE_RESET      = 8'h8c;
   localparam logic [2:0]  HRC_RESET       = 3'h3;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int          CLK_HZ          = 20_000_000;
   localparam int          FAST_STABLE_CYC = 512;
   localparam int          IRC_STABLE_CYC  = 4;
   localparam int          XTAL_STABLE_CYC = 1024;
   localparam int          RTC_BITS        = 14;
   localparam int          SLOW_HZ         = 32_768;
   localparam int          HRC_TOP_HZ      = 8_000_000;
   // Slow tick derived from the system clock, at least one cycle
   localparam int          SLOW_DIV_CYC    = (CLK_HZ / SLOW_HZ) < 1 ? 1 : CLK_HZ / SLOW_HZ;
   localparam int          FAST_DIV_CYC    = (CLK_HZ / HRC_TOP_HZ) < 1 ? 1 : CLK_HZ / HRC_TOP_HZ;

   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_SLOW,
      MODE_STANDBY,
      MODE_HALT
   } dcpm_mode_t;

   typedef struct packed {
      logic       key_change;
      logic [2:0] timer_irq;
      logic [1:0] aux_timer_irq;
      logic       ext_irq;
      logic       key_strobe_irq;
      logic       key_strobe_wake;
   } dcpm_wake_t;

   typedef struct packed {
      logic                cpu_clk_en;
      logic                fast_osc_on;
      logic                slow_osc_on;
      logic                divided_fast_en;
      logic                slow_en;
      logic [RTC_BITS-1:0] rtc_taps;
   } dcpm_clk_t;
endpackage
`default_nettype wire

// file: dcpm_consumer.sv
`timescale 1ns/1ps
`default_nettype none
module dcpm_consumer (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        cpu_clock,
   input  wire logic        divided_fast_clock,
   input  wire logic        xtal_out,
   input  wire logic        xtal_out_en,
   output logic             xtal_in,
   output logic [31:0]      cpu_ticks,
   output logic [31:0]      fast_ticks
);
   // ----------------------------------------
   // Clock consumers and crystal
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_ticks  <= 32'h0;
         fast_ticks <= 32'h0;
      end else begin
         cpu_ticks  <= cpu_ticks + 32'(cpu_clock);
         fast_ticks <= fast_ticks + 32'(divided_fast_clock);
      end
   end
   // An undriven crystal node wanders, so it toggles rather than holding
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) xtal_in <= 1'b0;
      else if (xtal_out_en) xtal_in <= xtal_out;
      else xtal_in <= !xtal_in;
   end
endmodule
`default_nettype wire

// file: dual_clock_power_mode_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module dual_clock_power_mode_control_test;
   import dcpm_pkg::*;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, xtal_in, xtal_out, xtal_out_en;
   logic        divided_fast_clock, slow_clock, cpu_clock;
   logic [31:0] haddr, hwdata, hrdata, cpu_ticks, fast_ticks, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   dcpm_wake_t  wake;
   dcpm_clk_t   clks;
   dcpm_mode_t  mode;
   int          fails, check_count, cyc;
   assign hready = hreadyout;
   dcpm_ctrl #(.RTC_W(RTC_BITS), .FAST_SETTLE(8), .XTAL_SETTLE(8)) u_dcpm_ctrl (
      .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .wake(wake), .xtal_in(xtal_in), .xtal_out(xtal_out), .xtal_out_en(xtal_out_en),
      .clks(clks), .divided_fast_clock(divided_fast_clock), .slow_clock(slow_clock),
      .cpu_clock(cpu_clock), .mode(mode));
   dcpm_consumer u_dcpm_consumer (
      .clk(clk), .rst_n(rst_n), .cpu_clock(cpu_clock), .divided_fast_clock(divided_fast_clock),
      .xtal_out(xtal_out), .xtal_out_en(xtal_out_en), .xtal_in(xtal_in), .cpu_ticks(cpu_ticks),
      .fast_ticks(fast_ticks));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic test_done();
      if (fails == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // Bounded wait; the limit covers the shortened oscillator settling
   task automatic wait_mode(input dcpm_mode_t m);
      for (int i = 0; i < 200 && mode !== m; i++) @(posedge clk);
      chk(32'(mode), 32'(m));
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      chk(32'(mode), 32'(MODE_NORMAL));
      bus(1'b0, ADDR_MODE_CTRL, 32'h0); chk(rd, {24'h0, MODE_RESET});
      bus(1'b0, ADDR_SLEEP_CMD, 32'h0); chk(rd, 32'h0);
      bus(1'b0, 32'h0000_0010, 32'h0); chk(rd, 32'h0);
      bus(1'b0, ADDR_OPTION, 32'h0); chk(rd, {29'h0, HRC_RESET});
      chk(32'(clks.fast_osc_on), 32'h1);
      chk(32'(hresp), 32'h0);
   endtask
   task automatic t_rtc_clear();
      int n;
      n = 0;
      // Slow pulse every 610 cycles, so 1300 cycles hold two or three
      for (int k = 0; k < 1300; k++) begin
         @(negedge clk);
         n += int'(slow_clock);
      end
      chk(32'(n >= 2 && n <= 3), 32'h1);
      chk(32'(clks.rtc_taps > 0), 32'h1);
      bus(1'b1, ADDR_MODE_CTRL, 32'h88);
      @(negedge clk);
      chk(32'(clks.rtc_taps), 32'h0);
      bus(1'b0, ADDR_MODE_CTRL, 32'h0); chk(rd, 32'h8c);
   endtask
   task automatic t_divider();
      logic [31:0] c0, c3;
      c0 = fast_ticks; repeat (2000) @(posedge clk); c0 = fast_ticks - c0;
      bus(1'b1, ADDR_MODE_CTRL, 32'hbc);
      c3 = fast_ticks; repeat (2000) @(posedge clk); c3 = fast_ticks - c3;
      chk(32'(c3 > 0 && c0 >= 7 * c3 && c0 <= 9 * c3), 32'h1);
      bus(1'b1, ADDR_MODE_CTRL, 32'h8c);
   endtask
   task automatic t_slow();
      logic [31:0] c;
      bus(1'b1, ADDR_MODE_CTRL, 32'h0c); wait_mode(MODE_SLOW);
      chk(32'(clks.fast_osc_on), 32'h0);
      chk(32'(clks.slow_en), 32'h1);
      // Let the last pulse of the fast clock land before counting
      @(negedge clk);
      c = fast_ticks;
      repeat (20) @(negedge clk);
      chk(fast_ticks - c, 32'h0);
      bus(1'b1, ADDR_MODE_CTRL, 32'h8c); wait_mode(MODE_NORMAL);
      chk(32'(clks.cpu_clk_en), 32'h0);
      c = cpu_ticks;
      repeat (20) @(negedge clk);
      chk(32'(clks.cpu_clk_en), 32'h1);
      chk(32'(cpu_ticks - c > 0), 32'h1);
   endtask
   task automatic t_xtal();
      logic x;
      bus(1'b1, ADDR_OPTION, 32'h13); repeat (4) @(posedge clk);
      chk(32'(xtal_out_en), 32'h1);
      // Crystal loop through the partner repeats every four cycles
      @(negedge clk);
      x = xtal_out;
      repeat (2) @(negedge clk);
      chk(32'(xtal_out), 32'(!x));
      bus(1'b1, ADDR_OPTION, 32'h03); repeat (4) @(posedge clk);
      chk(32'(xtal_out_en), 32'h0);
   endtask
   task automatic t_standby();
      logic [31:0] c;
      bus(1'b1, ADDR_SLEEP_CMD, 32'h5b); repeat (4) @(posedge clk);
      chk(32'(mode), 32'(MODE_NORMAL));
      // One pass per wake source, all nine of them
      for (int i = 0; i < 9; i++) begin
         bus(1'b1, ADDR_SLEEP_CMD, 32'h5a); wait_mode(MODE_STANDBY);
         chk(32'(clks.cpu_clk_en), 32'h0);
         chk(32'(clks.slow_en), 32'h1);
         @(negedge clk);
         c = cpu_ticks;
         repeat (8) @(negedge clk);
         chk(cpu_ticks - c, 32'h0);
         @(posedge clk);
         wake <= dcpm_wake_t'(9'h001 << i);
         wait_mode(MODE_NORMAL);
         wake <= '0;
      end
   endtask
   task automatic t_halt();
      bus(1'b1, ADDR_MODE_CTRL, 32'h04); wait_mode(MODE_SLOW);
      bus(1'b1, ADDR_SLEEP_CMD, 32'h5a); wait_mode(MODE_HALT);
      chk(32'(clks.slow_en), 32'h0);
      wake <= dcpm_wake_t'(9'h0fb);
      repeat (50) @(posedge clk);
      chk(32'(mode), 32'(MODE_HALT));
      wake <= dcpm_wake_t'(9'h004);
      wait_mode(MODE_SLOW);
      wake <= '0;
      bus(1'b1, ADDR_MODE_CTRL, 32'h8c); wait_mode(MODE_NORMAL);
   endtask
   // ----------------------------------------
   // Clock, reset, timeout and sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails++;
         test_done();
      end
   end
   initial begin
      fails = 0; check_count = 0; cyc = 0; rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0;
      htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; wake = '0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      // Real-time clock stays enabled while busy, as software is told to, except in t_halt, which turns it off to reach halt
      t_reset(); t_rtc_clear(); t_divider(); t_slow(); t_xtal(); t_standby(); t_halt();
      test_done();
   end
endmodule
`default_nettype wire
